// ===== core/mrsel_host.sv
// host controller driving a 2048 x 8 mask rom with three programmable selects
// optionally checks the rom against a B/P/N/F image stream, word by word
// assumes data pins come from another timing domain and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "mrsel_params.svh"
module mrsel_host
   import mrsel_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        rd_req_i,
   input  wire logic [10:0] rd_addr_i,
   input  wire logic [2:0]  mask_select_code_i,
   input  wire logic        char_valid_i,
   input  wire logic [7:0]  char_i,
   input  wire logic [7:0]  rom_data_i,
   output logic [10:0]      rom_addr_o,
   output logic             select_input_first_o,
   output logic             select_input_second_o,
   output logic             select_input_third_o,
   output logic             rd_busy_o,
   output logic             rd_valid_o,
   output logic [7:0]       rd_data_o,
   output logic             img_mismatch_o,
   output logic             img_error_o,
   output logic             img_done_o
);
   localparam logic [7:0] SETTLE = 8'(`MRSEL_SETTLE_CYC);
   mrsel_state_t st_reg, st_next;
   logic [7:0]  wait_reg;
   logic [7:0]  s1_reg, s2_reg;
   logic [10:0] img_addr_reg;
   logic        img_done_reg, chk_pend_reg, chk_src_reg;
   logic [7:0]  chk_word_reg;
   mrsel_img_if img();

   mrsel_img_parser u_parser (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .char_valid_i (char_valid_i),
      .char_i       (char_i),
      .img          (img)
   );

   // image word requests pre-empt user reads only when the engine is idle
   wire start_img = (st_reg == MRSEL_IDLE) && chk_pend_reg;
   wire start_usr = (st_reg == MRSEL_IDLE) && !chk_pend_reg && rd_req_i;
   wire settled   = wait_reg == 8'h00;

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         MRSEL_IDLE:  if (start_img || start_usr) st_next = MRSEL_DRIVE;
         MRSEL_DRIVE: st_next = MRSEL_WAIT;
         MRSEL_WAIT:  if (settled) st_next = MRSEL_DONE;
         MRSEL_DONE:  st_next = MRSEL_IDLE;
      endcase
   end

   // data pins are asynchronous to us, so two flops before any use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
      end else begin
         s1_reg <= rom_data_i;
         s2_reg <= s1_reg;
      end
   end

   // address and select pins held steady for the whole access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg                <= MRSEL_IDLE;
         wait_reg              <= 8'h00;
         rom_addr_o            <= 11'h000;
         select_input_first_o  <= 1'b1;
         select_input_second_o <= 1'b1;
         select_input_third_o  <= 1'b1;
         chk_src_reg           <= 1'b0;
      end else begin
         st_reg <= st_next;
         if (start_img || start_usr) begin
            rom_addr_o  <= start_img ? img_addr_reg : rd_addr_i;
            chk_src_reg <= start_img;
            wait_reg    <= SETTLE; // settle time plus sync latency covered below
            // drive the code so the rom selects: msb to third, lsb to first
            select_input_third_o  <= mask_select_code_i[2];
            select_input_second_o <= mask_select_code_i[1];
            select_input_first_o  <= mask_select_code_i[0];
         end else if (st_reg == MRSEL_WAIT && !settled) begin
            wait_reg <= wait_reg - 8'h01;
         end else if (st_reg == MRSEL_DONE) begin
            // inverted code deselects, releasing the shared bus
            select_input_third_o  <= ~mask_select_code_i[2];
            select_input_second_o <= ~mask_select_code_i[1];
            select_input_first_o  <= ~mask_select_code_i[0];
         end
      end
   end

   // one pending image word at a time; stream source must pace itself on busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_valid_o     <= 1'b0;
         rd_data_o      <= 8'h00;
         rd_busy_o      <= 1'b0;
         img_mismatch_o <= 1'b0;
         img_error_o    <= 1'b0;
         img_done_o     <= 1'b0;
         img_done_reg   <= 1'b0;
         img_addr_reg   <= 11'h000;
         chk_pend_reg   <= 1'b0;
         chk_word_reg   <= 8'h00;
      end else begin
         rd_busy_o  <= (st_next != MRSEL_IDLE) || chk_pend_reg;
         rd_valid_o <= (st_reg == MRSEL_DONE) && !chk_src_reg;
         if (st_reg == MRSEL_DONE && !chk_src_reg) rd_data_o <= s2_reg;
         if (img.field_error) img_error_o <= 1'b1;
         if (img.word_valid && !img_done_reg) begin
            chk_pend_reg <= 1'b1;
            chk_word_reg <= img.word_data;
         end else if (start_img) begin
            chk_pend_reg <= 1'b0;
         end
         if (st_reg == MRSEL_DONE && chk_src_reg) begin
            if (s2_reg != chk_word_reg) img_mismatch_o <= 1'b1;
            if (img_addr_reg == `MRSEL_LAST_ADDR) img_done_reg <= 1'b1;
            img_addr_reg <= img_addr_reg + 11'h001;
         end
         img_done_o <= img_done_reg;
      end
   end
endmodule
`default_nettype wire

// ===== core/mrsel_img_if.sv
// carries decoded image words from the parser to the host top
// assumes a single clock owned by the instantiating module
`timescale 1ns/1ps
`default_nettype none
interface mrsel_img_if;
   logic       word_valid;
   logic [7:0] word_data;
   logic       field_error;
   modport parser (output word_valid, output word_data, output field_error);
   modport top    (input word_valid, input word_data, input field_error);
endinterface
`default_nettype wire

// ===== core/mrsel_img_parser.sv
// parses a B/P/N/F character stream into image words
// assumes characters arrive one per valid cycle from same-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "mrsel_params.svh"
module mrsel_img_parser
   import mrsel_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        char_valid_i,
   input  wire logic [7:0]  char_i,
   mrsel_img_if.parser      img
);
   mrsel_pstate_t st_reg, st_next;
   logic [7:0] sh_reg;
   logic [3:0] cnt_reg;
   logic       wv_reg;
   wire is_b = char_i == `MRSEL_CH_START;
   wire is_f = char_i == `MRSEL_CH_END;
   wire is_p = char_i == `MRSEL_CH_ONE;
   wire is_n = char_i == `MRSEL_CH_ZERO;
   wire full = cnt_reg == 4'h8;
   // comments between fields are skipped; inside a field only P/N then F is legal
   always_comb begin
      st_next = st_reg;
      if (char_valid_i) begin
         unique case (st_reg)
            MRSEL_PIDLE, MRSEL_PEND, MRSEL_PBAD: begin
               st_next = is_b ? MRSEL_PSTRT : MRSEL_PIDLE;
            end
            MRSEL_PSTRT, MRSEL_PDATA: begin
               if (is_f && full) st_next = MRSEL_PEND;
               else if ((is_p || is_n) && !full) st_next = MRSEL_PDATA;
               else st_next = MRSEL_PBAD;
            end
            default: st_next = MRSEL_PIDLE;
         endcase
      end
   end
   // first data character lands in the msb after eight shifts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg  <= MRSEL_PIDLE;
         sh_reg  <= 8'h00;
         cnt_reg <= 4'h0;
         wv_reg  <= 1'b0;
      end else begin
         st_reg <= st_next;
         // one pulse per field; the end state lingers until the next character
         wv_reg <= char_valid_i && st_next == MRSEL_PEND;
         if (char_valid_i && st_next == MRSEL_PSTRT) cnt_reg <= 4'h0;
         if (char_valid_i && st_next == MRSEL_PDATA) begin
            sh_reg  <= {sh_reg[6:0], is_p};
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
   assign img.word_valid  = wv_reg;
   assign img.word_data   = sh_reg;
   assign img.field_error = (st_reg == MRSEL_PBAD);
endmodule
`default_nettype wire

// ===== core/mrsel_params.svh
// constants for the mask rom host controller: array shape, select code, image characters
// assumes inclusion by the host top, its parser module and the type package
// Overview of operation
// - image words listed ascending from address zero to the top address
// - each image word written msb first, lsb last
// - P means logic 1 high level, N means logic 0 low level
// - in stream form each word sits between B start and F end
// - exactly 8 data characters between B and F, nothing else
`ifndef MRSEL_PARAMS_SVH
`define MRSEL_PARAMS_SVH
`define MRSEL_ADDR_W      11
`define MRSEL_DATA_W      8
`define MRSEL_DEPTH       2048
`define MRSEL_LAST_ADDR   11'h7ff
`define MRSEL_CODE_RESET  3'h0
`define MRSEL_CH_START    8'h42
`define MRSEL_CH_END      8'h46
`define MRSEL_CH_ONE      8'h50
`define MRSEL_CH_ZERO     8'h4e
`define MRSEL_ACCESS_NS   850
`define MRSEL_SETTLE_CYC  ((`MRSEL_ACCESS_NS + 4) / 5)
`endif

// ===== core/mrsel_pkg.sv
// types for the mask rom host controller
// assumes mrsel_params.svh for widths
`include "mrsel_params.svh"
package mrsel_pkg;
   typedef logic [`MRSEL_ADDR_W-1:0] mrsel_addr_t;
   typedef logic [`MRSEL_DATA_W-1:0] mrsel_data_t;
   typedef enum logic [1:0] {
      MRSEL_IDLE  = 2'b00,
      MRSEL_DRIVE = 2'b01,
      MRSEL_WAIT  = 2'b10,
      MRSEL_DONE  = 2'b11
   } mrsel_state_t;
   typedef enum logic [2:0] {
      MRSEL_PIDLE = 3'b000,
      MRSEL_PSTRT = 3'b001,
      MRSEL_PDATA = 3'b010,
      MRSEL_PEND  = 3'b011,
      MRSEL_PBAD  = 3'b100
   } mrsel_pstate_t;
endpackage

// ===== tb/mrsel_host_asserts.sv
// assertions on the mask rom host ports
// assumes binding to mrsel_host, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module mrsel_host_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        rd_req_i,
   input wire logic [10:0] rd_addr_i,
   input wire logic [2:0]  mask_select_code_i,
   input wire logic [10:0] rom_addr_o,
   input wire logic        select_input_first_o,
   input wire logic        select_input_second_o,
   input wire logic        select_input_third_o,
   input wire logic        rd_busy_o,
   input wire logic        rd_valid_o,
   input wire logic        img_error_o
);
   wire logic [2:0] sel = {select_input_third_o, select_input_second_o, select_input_first_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request counts only while the engine is idle
   sequence s_take;
      rd_req_i && !rd_busy_o;
   endsequence
   a_take_busy: assert property (s_take |=> rd_busy_o) else $error("take ignored");
   a_addr_load: assert property (s_take |=> rom_addr_o == $past(rd_addr_i))
      else $error("bad address");
   a_sel_match: assert property (s_take |=> sel == $past(mask_select_code_i))
      else $error("select code");
   a_addr_hold: assert property (s_take |=> ##1 $stable(rom_addr_o)[*8])
      else $error("address moved");
   a_answer_time: assert property (s_take |-> ##[170:180] rd_valid_o)
      else $error("late answer");
   a_deselect: assert property (rd_valid_o |-> sel == ~mask_select_code_i && !rd_busy_o)
      else $error("no release");
   a_valid_pulse: assert property (rd_valid_o |=> !rd_valid_o) else $error("long pulse");
   a_error_sticky: assert property ($rose(img_error_o) |=> img_error_o[*8])
      else $error("error dropped");
endmodule
bind mrsel_host mrsel_host_asserts u_chk (.*);
`default_nettype wire

// ===== tb/mrsel_host_test.sv
// testbench for the mask rom host: table of reads, reset state, image compare
// assumes the rom model answers combinationally on the data pins
`timescale 1ns/1ps
`default_nettype none
module mrsel_host_test;
   logic            clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            rd_req_i = 1'b0;
   logic            char_valid_i = 1'b0;
   logic [10:0]     rd_addr_i = 11'h000;
   logic [2:0]      mask_select_code_i = 3'h0;
   logic [7:0]      char_i = 8'h00;
   wire logic [7:0] rom_data_i, rd_data_o;
   wire logic [10:0] rom_addr_o;
   wire logic       select_input_first_o, select_input_second_o, select_input_third_o;
   wire logic       rd_busy_o, rd_valid_o, img_mismatch_o, img_error_o, img_done_o;
   wire logic [2:0] sel = {select_input_third_o, select_input_second_o, select_input_first_o};
   int              n_fail = 0;
   int              samples_checked = 0;
   int              k;
   // rows: select code in the top three bits, address below; every code at least once, code 7 twice
   logic [13:0]     rows [9] = '{14'h0000, 14'h0fff, 14'h1001, 14'h1c00, 14'h22aa,
                                14'h2d55, 14'h3100, 14'h3bff, 14'h3800};

   mrsel_host dut (.*);
   mrsel_rom_model rom (.addr_i(rom_addr_o), .sel_i(sel), .code_i(mask_select_code_i),
                        .data_o(rom_data_i));

   initial forever #2.5 clk_i = ~clk_i;

   function automatic logic [7:0] exp_word(input logic [10:0] a);
      return a[7:0] ^ {a[10:8], 5'h15};
   endfunction
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // bounded wait on the answer pulse or on the engine going idle
   task automatic wait_for(input bit on_valid);
      for (k = 0; k < 400; k++) begin
         @(negedge clk_i);
         if (on_valid ? rd_valid_o === 1'b1 : rd_busy_o === 1'b0) return;
      end
      n_fail++;
      report_and_stop();
   endtask
   task automatic rd(input logic [13:0] row);
      mask_select_code_i = row[13:11];
      rd_addr_i = row[10:0];
      rd_req_i = 1'b1;
      @(negedge clk_i);
      rd_req_i = 1'b0;
      @(negedge clk_i);
      chk(sel, row[13:11]);
      chk(rom_addr_o, row[10:0]);
      wait_for(1'b1);
      chk(rd_data_o, exp_word(row[10:0]));
      chk(sel, 3'(~row[13:11]));
      // code must hold while the answer pulse stands
      @(negedge clk_i);
   endtask
   task automatic send(input logic [7:0] c);
      char_valid_i = 1'b1;
      char_i = c;
      @(negedge clk_i);
      char_valid_i = 1'b0;
      @(negedge clk_i);
   endtask
   // one field: start, n data characters msb first, end; then pace on busy
   task automatic img(input logic [7:0] w, input int n);
      send(8'h42);
      for (int b = 7; b > 7 - n; b--) send(w[b] ? 8'h50 : 8'h4e);
      send(8'h46);
      repeat (3) @(negedge clk_i);
      wait_for(1'b0);
   endtask

   initial begin
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      chk({rd_busy_o, rd_valid_o, img_mismatch_o, img_error_o, img_done_o, sel}, 11'h007);
      foreach (rows[i]) rd(rows[i]);
      img(exp_word(11'h000), 8);
      chk(img_mismatch_o, 1'b0);
      img(~exp_word(11'h001), 8);
      chk(img_mismatch_o, 1'b1);
      chk(img_error_o, 1'b0);
      img(8'h00, 3);
      chk(img_error_o, 1'b1);
      chk(img_done_o, 1'b0);
      // mid-run reset clears sticky flags and a read works right after
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      chk({rd_busy_o, rd_valid_o, img_mismatch_o, img_error_o, img_done_o, sel}, 11'h007);
      rd(rows[2]);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== tb/mrsel_rom_model.sv
// rom device model: 2048 x 8 words, three selects matched against a mask code
// assumes the host drives address and selects; no clock, no reset
`timescale 1ns/1ps
`default_nettype none
module mrsel_rom_model (
   input  wire logic [10:0] addr_i,
   input  wire logic [2:0]  sel_i,
   input  wire logic [2:0]  code_i,
   output logic [7:0]       data_o
);
   logic [7:0] mem [2048];
   logic [7:0] last_reg = 8'h00;
   wire logic  hit = (sel_i === code_i);
   // words differ from neighbours so an aliased address shows up
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ {i[10:8], 5'h15};
   // floating bus shown as inverse of last word, never as a stale copy
   assign data_o = hit ? mem[addr_i] : ~last_reg;
   // compare the pins directly: the hit net may not have settled yet here
   always @(addr_i, sel_i, code_i) if (sel_i === code_i) last_reg = mem[addr_i];
endmodule
`default_nettype wire
